// >>> logic/rx_consts.vh
`ifndef RX_CONSTS_VH
`define RX_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets on the Wishbone port.
// ----------------------------------------------------------------
`define OFS_MODE 8'h00
`define OFS_MAN 8'h04
`define OFS_CTRL 8'h08
`define OFS_STATUS 8'h0C
`define OFS_RHR 8'h10
`define OFS_BAUD 8'h14

// ----------------------------------------------------------------
// Field positions of mode_register_word.
// ----------------------------------------------------------------
`define MD_SYNC 0
`define MD_OVER 1
`define MD_CLEN_LO 2
`define MD_CLEN_HI 3
`define MD_NINE 4
`define MD_MSB_FIRST 5
`define MD_PAR_LO 6
`define MD_PAR_HI 8
`define MD_STOPS_LO 9
`define MD_STOPS_HI 10
`define MD_MAN 11
`define MD_ONE_CELL 12
`define MD_WIDTH 13

// ----------------------------------------------------------------
// Field positions of manchester_config_register.
// ----------------------------------------------------------------
`define MC_PL_LO 0
`define MC_PL_HI 3
`define MC_PP_LO 4
`define MC_PP_HI 5
`define MC_POL 6
`define MC_WIDTH 7

// ----------------------------------------------------------------
// Command bits of control_register_word.
// ----------------------------------------------------------------
`define CR_ENABLE 0
`define CR_RXDIS 1
`define CR_CLEAR 2

// ----------------------------------------------------------------
// Status bits of channel_status_register and holding register.
// ----------------------------------------------------------------
`define SR_RDY 0
`define SR_OVR 1
`define SR_PERR 2
`define SR_FRAME 3
`define SR_CODE 4
`define SR_EN 5
`define RHR_SYNC 15

// ----------------------------------------------------------------
// Encodings and reset values.
// ----------------------------------------------------------------
`define PAR_EVEN 3'h0
`define PAR_ODD 3'h1
`define PAR_SPACE 3'h2
`define PAR_MARK 3'h3
`define PP_ALL_ONE 2'h0
`define PP_ALL_ZERO 2'h1
`define PP_ONE_ZERO 2'h2
`define PP_ZERO_ONE 2'h3
`define RST_MODE 13'h00C0
`define RST_MAN 7'h00
`define RST_BAUD 16'h0043
`define OS16_LEN 5'h10
`define OS8_LEN 5'h08
`define SYNC_LEN 5'h01

`endif

// >>> logic/in_sync3.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Three-stage input synchroniser with agreement filter.
// ----------------------------------------------------------------
module in_sync3 (
	input wire clk,
	input wire rst_n,
	input wire din,
	output reg filt_q
);

	reg s1_q; // First stage, read only by the second stage.
	reg s2_q; // Second stage.
	reg s3_q; // Third stage.

	// The output follows only once stages two and three agree, which
	// drops single-cycle glitches at the cost of one extra cycle.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			filt_q <= 1'b1;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				filt_q <= s3_q;
			end
		end
	end

endmodule

// >>> logic/serial_rx.v
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "rx_consts.vh"

module serial_rx (
	input wire MCLK,
	input wire RESETN,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output reg [31:0] WB_DAT_O,
	output reg WB_ACK_O,
	input wire RXD,
	input wire SCK
);

	// ----------------------------------------------------------------
	// Receiver states.
	// ----------------------------------------------------------------
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_DATA = 4'h1;
	localparam [3:0] ST_PAR = 4'h2;
	localparam [3:0] ST_STOP = 4'h3;
	localparam [3:0] ST_MHUNT = 4'h4;
	localparam [3:0] ST_MPRE = 4'h5;
	localparam [3:0] ST_MSFD = 4'h6;
	localparam [3:0] ST_MDATA = 4'h7;
	localparam [3:0] ST_MPAR = 4'h8;

	// ----------------------------------------------------------------
	// Registers and wires.
	// ----------------------------------------------------------------
	reg [`MD_WIDTH-1:0] mode_q; // Character format and mode bits.
	reg [`MC_WIDTH-1:0] man_q; // Manchester receive configuration.
	reg [15:0] baud_q; // Sampling clock divider minus one.
	reg [15:0] div_q; // Divider counter.
	reg en_q; // Receiver enabled.
	reg rdy_q; // Holding register full.
	reg ovr_q; // Overrun seen.
	reg parity_error_flag_q; // Parity error seen.
	reg frame_q; // Framing error seen.
	reg manchester_error_flag_q; // Manchester code violation seen.
	reg [8:0] rhr_q; // Received character.
	reg rsync_q; // Sync kind of the held character.
	reg [3:0] st_q; // Receiver state.
	reg [4:0] cnt_q; // Sample counter within a bit or half bit.
	reg [4:0] low_q; // Consecutive low samples while hunting.
	reg [3:0] idx_q; // Bit index within the current phase.
	reg [8:0] data_q; // Character being assembled.
	reg pacc_q; // Running parity of data bits.
	reg perr_q; // Parity error of the current character.
	reg ferr_q; // Framing error of the current character.
	reg csync_q; // Sync kind of the current character.
	reg fin_q; // One-cycle pulse: current character is complete.
	reg half_q; // Next Manchester sample is the second half.
	reg h1_q; // First-half sample of the current cell.
	reg armed_q; // Line seen high since hunting began.
	reg [5:0] sfd_q; // Half samples of a sync delimiter.
	reg [2:0] hcnt_q; // Half samples collected for the sync.
	reg sck_q; // Previous filtered baud clock level.
	reg ack_q; // Wishbone acknowledge.
	wire rxd_f; // Filtered receive line.
	wire sck_f; // Filtered synchronous baud clock.
	wire sync_md; // Synchronous mode.
	wire man_md; // Manchester mode, asynchronous only.
	wire [2:0] pmode; // Parity mode.
	wire par_on; // Parity bit expected.
	wire [3:0] nbits; // Data bits per character.
	wire [3:0] pos; // Storage position of the next data bit.
	wire [4:0] bit_len; // Samples per bit.
	wire [4:0] half_len; // Samples per half bit.
	wire [4:0] qtr_len; // Samples per quarter bit.
	wire [4:0] thr; // Low samples that declare a start.
	wire [3:0] plen; // Preamble length in cells.
	wire line; // Receive line after polarity.
	wire tick; // Sampling event.
	wire par_bad; // Sampled parity bit disagrees.
	wire pbit; // Received bit value; a Manchester zero is low-high.
	wire pre_exp; // Expected preamble cell value.
	wire wr_ev; // Write takes effect this edge.
	wire rd_ev; // Read completes this edge.
	wire rhr_rd; // Holding register is read this edge.
	wire stat_clr; // Status reset command written.

	in_sync3 u_rxd (
		.clk(MCLK),
		.rst_n(RESETN),
		.din(RXD),
		.filt_q(rxd_f)
	);

	in_sync3 u_sck (
		.clk(MCLK),
		.rst_n(RESETN),
		.din(SCK),
		.filt_q(sck_f)
	);

	// ----------------------------------------------------------------
	// Decoded configuration.
	// ----------------------------------------------------------------
	assign sync_md = mode_q[`MD_SYNC];
	assign man_md = mode_q[`MD_MAN] & ~sync_md;
	assign pmode = mode_q[`MD_PAR_HI:`MD_PAR_LO];
	assign par_on = (pmode <= `PAR_MARK);
	assign nbits = mode_q[`MD_NINE] ? 4'h9 :
		({2'b00, mode_q[`MD_CLEN_HI:`MD_CLEN_LO]} + 4'h5);
	assign pos = mode_q[`MD_MSB_FIRST] ? (nbits - 4'h1 - idx_q) : idx_q;
	assign bit_len = sync_md ? `SYNC_LEN :
		(mode_q[`MD_OVER] ? `OS8_LEN : `OS16_LEN);
	assign half_len = {1'b0, bit_len[4:1]};
	assign qtr_len = {2'b00, bit_len[4:2]};
	assign thr = sync_md ? `SYNC_LEN : half_len;
	assign plen = man_q[`MC_PL_HI:`MC_PL_LO];
	assign line = rxd_f ^ (man_md & man_q[`MC_POL]);
	assign tick = sync_md ? (sck_f & ~sck_q) : (div_q == baud_q);

	// A Manchester cell carries its value in the first half, so the
	// value is the inverse of the second-half sample taken at 3/4.
	assign pbit = line ^ man_md;
	assign par_bad = (pmode == `PAR_EVEN) ? (pbit != pacc_q) :
		(pmode == `PAR_ODD) ? (pbit == pacc_q) :
		(pmode == `PAR_SPACE) ? pbit : ~pbit;

	assign pre_exp = (man_q[`MC_PP_HI:`MC_PP_LO] == `PP_ALL_ONE) ? 1'b1 :
		(man_q[`MC_PP_HI:`MC_PP_LO] == `PP_ALL_ZERO) ? 1'b0 :
		(man_q[`MC_PP_HI:`MC_PP_LO] == `PP_ONE_ZERO) ? ~idx_q[0] :
		idx_q[0];

	// ----------------------------------------------------------------
	// Wishbone decode.
	// ----------------------------------------------------------------
	assign wr_ev = WB_CYC_I & WB_STB_I & WB_WE_I & ack_q;
	assign rd_ev = WB_CYC_I & WB_STB_I & ~WB_WE_I & ack_q;
	assign rhr_rd = rd_ev & (WB_ADR_I == `OFS_RHR);
	assign stat_clr = wr_ev & (WB_ADR_I == `OFS_CTRL) & WB_SEL_I[0] &
		WB_DAT_I[`CR_CLEAR];

	// The acknowledge comes one cycle after the request and drops at
	// once; a held request is acknowledged again every second cycle.
	always @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			ack_q <= 1'b0;
			WB_ACK_O <= 1'b0;
		end else begin
			ack_q <= WB_CYC_I & WB_STB_I & ~ack_q;
			WB_ACK_O <= WB_CYC_I & WB_STB_I & ~ack_q;
		end
	end

	// Read data is captured with the acknowledge; unmapped reads give 0.
	always @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			WB_DAT_O <= 32'h00000000;
		end else if (WB_CYC_I & WB_STB_I & ~ack_q) begin
			case (WB_ADR_I)
				`OFS_MODE: WB_DAT_O <= {19'h00000, mode_q};
				`OFS_MAN: WB_DAT_O <= {25'h0000000, man_q};
				`OFS_STATUS: WB_DAT_O <= {26'h0000000, en_q, manchester_error_flag_q,
					frame_q, parity_error_flag_q, ovr_q, rdy_q};
				`OFS_RHR: WB_DAT_O <= {16'h0000, rsync_q, 6'h00, rhr_q};
				`OFS_BAUD: WB_DAT_O <= {16'h0000, baud_q};
				default: WB_DAT_O <= 32'h00000000;
			endcase
		end
	end

	// Configuration registers honour byte selects; they may be written
	// while the receiver is disabled.
	always @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			mode_q <= `RST_MODE;
			man_q <= `RST_MAN;
			baud_q <= `RST_BAUD;
		end else if (wr_ev) begin
			if (WB_ADR_I == `OFS_MODE) begin
				if (WB_SEL_I[0]) begin
					mode_q[7:0] <= WB_DAT_I[7:0];
				end
				if (WB_SEL_I[1]) begin
					mode_q[12:8] <= WB_DAT_I[12:8];
				end
			end
			if ((WB_ADR_I == `OFS_MAN) && WB_SEL_I[0]) begin
				man_q <= WB_DAT_I[6:0];
			end
			if (WB_ADR_I == `OFS_BAUD) begin
				if (WB_SEL_I[0]) begin
					baud_q[7:0] <= WB_DAT_I[7:0];
				end
				if (WB_SEL_I[1]) begin
					baud_q[15:8] <= WB_DAT_I[15:8];
				end
			end
		end
	end

	// Sampling clock divider; also keeps the previous baud clock level.
	always @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			div_q <= 16'h0000;
			sck_q <= 1'b1;
		end else begin
			sck_q <= sck_f;
			if (div_q >= baud_q) begin
				div_q <= 16'h0000;
			end else begin
				div_q <= div_q + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Receiver state machine and status flags.
	// ----------------------------------------------------------------
	// Flag clears are written first so that a set in the same cycle,
	// written later, wins.
	always @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			en_q <= 1'b0;
			rdy_q <= 1'b0;
			ovr_q <= 1'b0;
			parity_error_flag_q <= 1'b0;
			frame_q <= 1'b0;
			manchester_error_flag_q <= 1'b0;
			rhr_q <= 9'h000;
			rsync_q <= 1'b0;
			st_q <= ST_IDLE;
			cnt_q <= 5'h00;
			low_q <= 5'h00;
			idx_q <= 4'h0;
			data_q <= 9'h000;
			pacc_q <= 1'b0;
			perr_q <= 1'b0;
			ferr_q <= 1'b0;
			csync_q <= 1'b0;
			fin_q <= 1'b0;
			half_q <= 1'b0;
			h1_q <= 1'b0;
			armed_q <= 1'b0;
			sfd_q <= 6'h00;
			hcnt_q <= 3'h0;
		end else begin
			fin_q <= 1'b0;
			if (wr_ev && (WB_ADR_I == `OFS_CTRL) && WB_SEL_I[0]) begin
				if (WB_DAT_I[`CR_RXDIS]) begin
					en_q <= 1'b0;
				end else if (WB_DAT_I[`CR_ENABLE]) begin
					en_q <= 1'b1;
				end
			end
			if (stat_clr) begin
				ovr_q <= 1'b0;
				parity_error_flag_q <= 1'b0;
				frame_q <= 1'b0;
				manchester_error_flag_q <= 1'b0;
			end
			if (rhr_rd) begin
				rdy_q <= 1'b0;
			end
			if (fin_q) begin
				rhr_q <= data_q;
				rsync_q <= csync_q;
				rdy_q <= 1'b1;
				if (rdy_q && !rhr_rd) begin
					ovr_q <= 1'b1;
				end
				if (perr_q) begin
					parity_error_flag_q <= 1'b1;
				end
				if (ferr_q) begin
					frame_q <= 1'b1;
				end
			end
			if (tick) begin
				case (st_q)
					ST_IDLE: begin
						if (en_q && man_md) begin
							st_q <= ST_MHUNT;
							armed_q <= 1'b0;
							low_q <= 5'h00;
						end else if (en_q && !line) begin
							if (low_q + 5'h01 >= thr) begin
								st_q <= ST_DATA;
								cnt_q <= 5'h00;
								idx_q <= 4'h0;
								data_q <= 9'h000;
								pacc_q <= 1'b0;
								perr_q <= 1'b0;
								csync_q <= 1'b0;
							end else begin
								low_q <= low_q + 5'h01;
							end
						end else begin
							low_q <= 5'h00;
						end
					end
					ST_DATA, ST_PAR, ST_STOP: begin
						if (cnt_q + 5'h01 >= bit_len) begin
							cnt_q <= 5'h00;
							if (st_q == ST_DATA) begin
								data_q[pos] <= line;
								pacc_q <= pacc_q ^ line;
								idx_q <= idx_q + 4'h1;
								if (idx_q == nbits - 4'h1) begin
									st_q <= par_on ? ST_PAR : ST_STOP;
								end
							end else if (st_q == ST_PAR) begin
								perr_q <= par_bad;
								st_q <= ST_STOP;
							end else begin
								ferr_q <= ~line;
								fin_q <= 1'b1;
								st_q <= ST_IDLE;
								low_q <= 5'h00;
							end
						end else begin
							cnt_q <= cnt_q + 5'h01;
						end
					end
					ST_MHUNT: begin
						if (!en_q || !man_md) begin
							st_q <= ST_IDLE;
						end else if (line) begin
							armed_q <= 1'b1;
							low_q <= 5'h00;
						end else if (armed_q) begin
							if (low_q + 5'h01 >= qtr_len) begin
								st_q <= (plen == 4'h0) ? ST_MSFD : ST_MPRE;
								h1_q <= 1'b0;
								half_q <= 1'b1;
								cnt_q <= 5'h00;
								idx_q <= 4'h0;
								sfd_q <= 6'h00;
								hcnt_q <= 3'h1;
								data_q <= 9'h000;
								pacc_q <= 1'b0;
								perr_q <= 1'b0;
								ferr_q <= 1'b0;
							end else begin
								low_q <= low_q + 5'h01;
							end
						end
					end
					ST_MPRE, ST_MSFD, ST_MDATA, ST_MPAR: begin
						if (cnt_q + 5'h01 >= half_len) begin
							cnt_q <= 5'h00;
							half_q <= ~half_q;
							sfd_q <= {sfd_q[4:0], line};
							hcnt_q <= hcnt_q + 3'h1;
							if (!half_q) begin
								h1_q <= line;
							end
						end else begin
							cnt_q <= cnt_q + 5'h01;
						end
						if ((cnt_q + 5'h01 >= half_len) && half_q) begin
							case (st_q)
								ST_MPRE: begin
									if ((h1_q == line) || (line == pre_exp)) begin
										st_q <= ST_MHUNT;
										armed_q <= 1'b0;
										low_q <= 5'h00;
									end else if (idx_q == plen - 4'h1) begin
										st_q <= ST_MSFD;
										idx_q <= 4'h0;
										sfd_q <= 6'h00;
										hcnt_q <= 3'h0;
									end else begin
										idx_q <= idx_q + 4'h1;
									end
								end
								ST_MSFD: begin
									if (mode_q[`MD_ONE_CELL]) begin
										if (!h1_q && line) begin
											st_q <= ST_MDATA;
											csync_q <= 1'b0;
										end else begin
											st_q <= ST_MHUNT;
											armed_q <= 1'b0;
											low_q <= 5'h00;
										end
									end
								end
								ST_MDATA: begin
									if (h1_q == line) begin
										manchester_error_flag_q <= 1'b1;
									end
									data_q[pos] <= pbit;
									pacc_q <= pacc_q ^ pbit;
									idx_q <= idx_q + 4'h1;
									if (idx_q == nbits - 4'h1) begin
										if (par_on) begin
											st_q <= ST_MPAR;
										end else begin
											fin_q <= 1'b1;
											st_q <= ST_MHUNT;
											armed_q <= 1'b0;
											low_q <= 5'h00;
										end
									end
								end
								default: begin
									if (h1_q == line) begin
										manchester_error_flag_q <= 1'b1;
									end
									perr_q <= par_bad;
									fin_q <= 1'b1;
									st_q <= ST_MHUNT;
									armed_q <= 1'b0;
									low_q <= 5'h00;
								end
							endcase
						end
						if ((st_q == ST_MSFD) && !mode_q[`MD_ONE_CELL] &&
							(cnt_q + 5'h01 >= half_len) &&
							(hcnt_q == 3'h5)) begin
							if ({sfd_q[4:0], line} == 6'h38) begin
								st_q <= ST_MDATA;
								csync_q <= 1'b1;
							end else if ({sfd_q[4:0], line} == 6'h07) begin
								st_q <= ST_MDATA;
								csync_q <= 1'b0;
							end else begin
								st_q <= ST_MHUNT;
								armed_q <= 1'b0;
								low_q <= 5'h00;
							end
						end
					end
					default: begin
						st_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

endmodule

// >>> tb/serial_rx_chk.sv
`timescale 1ns/1ps
`include "rx_consts.vh"

// ----------------------------------------------------------------
// Port checker for the receiver: bus handshake and readback.
// ----------------------------------------------------------------
module serial_rx_chk (
	input wire MCLK,
	input wire RESETN,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	input wire [31:0] WB_DAT_O,
	input wire WB_ACK_O,
	input wire RXD,
	input wire SCK
);
	// Shadow copies of the mode and Manchester words and the enable state.
	reg [12:0] mode_q;
	reg [6:0] man_q;
	reg en_q;
	wire wr_ack = WB_ACK_O & WB_WE_I & (WB_SEL_I == 4'hF);
	wire rd_ack = WB_ACK_O & ~WB_WE_I;

	// Shadows change only at the ack edge, as the write does.
	always @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			mode_q <= `RST_MODE;
			man_q <= `RST_MAN;
			en_q <= 1'b0;
		end else if (wr_ack) begin
			if (WB_ADR_I == `OFS_MODE) mode_q <= WB_DAT_I[12:0];
			if (WB_ADR_I == `OFS_MAN) man_q <= WB_DAT_I[6:0];
			if (WB_ADR_I == `OFS_CTRL && WB_DAT_I[1:0] != 2'h0)
				en_q <= ~WB_DAT_I[1];
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESETN);

	property p_ack_req;
		WB_ACK_O |-> $past(WB_CYC_I & WB_STB_I);
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("stray ack");
	property p_ack_once;
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("long ack");
	property p_ack_lat;
		$rose(WB_CYC_I & WB_STB_I) |=> WB_ACK_O;
	endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("late ack");
	property p_mode_rb;
		rd_ack && WB_ADR_I == `OFS_MODE |-> WB_DAT_O == {19'h0, mode_q};
	endproperty
	a_mode_rb: assert property (p_mode_rb) else $error("mode read");
	property p_man_rb;
		rd_ack && WB_ADR_I == `OFS_MAN |-> WB_DAT_O == {25'h0, man_q};
	endproperty
	a_man_rb: assert property (p_man_rb) else $error("man read");
	property p_en_bit;
		rd_ack && WB_ADR_I == `OFS_STATUS |-> WB_DAT_O[`SR_EN] == en_q;
	endproperty
	a_en_bit: assert property (p_en_bit) else $error("enable bit");
	property p_zero_rd;
		rd_ack && (WB_ADR_I == `OFS_CTRL || WB_ADR_I > `OFS_BAUD)
			|-> WB_DAT_O == 32'h0;
	endproperty
	a_zero_rd: assert property (p_zero_rd) else $error("zero read");
	property p_rhr_shape;
		rd_ack && WB_ADR_I == `OFS_RHR
			|-> WB_DAT_O[31:16] == 16'h0 && WB_DAT_O[14:9] == 6'h0;
	endproperty
	a_rhr_shape: assert property (p_rhr_shape) else $error("rhr bits");

	c_ready: cover property (rd_ack && WB_ADR_I == `OFS_STATUS
		&& WB_DAT_O[`SR_RDY]);
	c_overrun: cover property (rd_ack && WB_ADR_I == `OFS_STATUS
		&& WB_DAT_O[`SR_OVR]);
	c_code_err: cover property (rd_ack && WB_ADR_I == `OFS_STATUS
		&& WB_DAT_O[`SR_CODE]);
endmodule

bind serial_rx serial_rx_chk i_chk (.MCLK(MCLK), .RESETN(RESETN),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
	.WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .RXD(RXD), .SCK(SCK));

// >>> tb/line_tx.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Remote sender: plays a level stream onto the serial line.
// ----------------------------------------------------------------
module line_tx (
	input wire clk,
	output logic rxd,
	output logic sck
);
	// The line idles at mark; the serial clock stands still low.
	initial begin
		rxd = 1'b1;
		sck = 1'b0;
	end

	// Unit i lasts per clocks; in clocked mode sck rises mid-unit.
	task automatic send(input logic [127:0] v, input int n,
		input int per, input logic syn);
		@(posedge clk);
		for (int i = 0; i < n; i++) begin
			rxd <= v[i];
			sck <= 1'b0;
			repeat (per / 2) @(posedge clk);
			sck <= syn;
			repeat (per - per / 2) @(posedge clk);
		end
		rxd <= 1'b1;
		sck <= 1'b0;
	endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "rx_consts.vh"

module testbench;
	// ----------------------------------------------------------------
	// Bench signals.
	// ----------------------------------------------------------------
	logic MCLK;
	logic RESETN;
	logic cyc, stb, we;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat_w, rv, m;
	wire [31:0] dat_o;
	wire ack, rxd, sck;
	int miscompares = 0;
	int comparisons = 0;

	serial_rx i_serial_rx (.MCLK(MCLK), .RESETN(RESETN),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .RXD(rxd), .SCK(sck));
	line_tx i_line_tx (.clk(MCLK), .rxd(rxd), .sck(sck));

	// Free-running 125 MHz clock.
	initial begin
		MCLK = 1'b0;
		forever #4 MCLK = ~MCLK;
	end

	task automatic final_report;
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One classic cycle; data is taken at the edge that sees ack.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge MCLK);
		{cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, 4'hF, d};
		k = 0;
		do begin
			@(posedge MCLK);
			k++;
		end while (ack !== 1'b1 && k < 50);
		rv = dat_o;
		{cyc, stb, we} <= 3'b000;
		if (k >= 50) begin
			check("ack", 32'h1, 32'h0);
			final_report;
		end
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a,
		input logic [31:0] e, input logic [31:0] msk);
		bus(1'b0, a, 32'h0);
		check(nm, e, rv & msk);
	endtask

	// Sends a frame, polls for ready, then checks status and char.
	task automatic rx(input logic [127:0] v, input int n, input int per,
		input logic syn, input logic [31:0] es, input logic [31:0] er,
		input logic [31:0] em);
		int k;
		i_line_tx.send(v, n, per, syn);
		k = 0;
		do begin
			bus(1'b0, `OFS_STATUS, 32'h0);
			k++;
		end while (rv[`SR_RDY] !== 1'b1 && k < 300);
		check("status", es, rv);
		if (k >= 300)
			final_report;
		rd_chk("rhr", `OFS_RHR, er, em);
	endtask

	// Manchester halves, default polarity: first half d, then ~d.
	function automatic logic [31:0] me(input logic [15:0] d);
		for (int i = 0; i < 16; i++) begin
			me[2 * i] = d[i];
			me[2 * i + 1] = ~d[i];
		end
	endfunction

	initial begin
		{cyc, stb, we, adr, sel, dat_w} = 47'h0;
		RESETN = 1'b0;
		repeat (2) @(posedge MCLK);
		RESETN <= 1'b1;
		rd_chk("mode", `OFS_MODE, `RST_MODE, '1);
		rd_chk("man", `OFS_MAN, `RST_MAN, '1);
		rd_chk("baud", `OFS_BAUD, `RST_BAUD, '1);
		rd_chk("hole", 8'h40, 32'h0, '1);
		bus(1'b1, `OFS_BAUD, 32'h1);
		bus(1'b1, `OFS_MODE, 32'h010C);
		// A frame sent before enabling must leave no trace.
		i_line_tx.send({1'b1, 8'h5A, 1'b0}, 10, 32, 1'b0);
		rd_chk("idle", `OFS_STATUS, 32'h0, '1);
		bus(1'b1, `OFS_CTRL, 32'h1);
		rx({1'b1, 8'hA5, 1'b0}, 10, 32, 0, 32'h21, 32'hA5, '1);
		// Two stops configured, one sent, frames back to back.
		bus(1'b1, `OFS_MODE, 32'h050C);
		rx({1'b1, 8'h3C, 2'b01, 8'hA5, 1'b0}, 20, 32, 0, 32'h23, 32'h3C,
			'1);
		bus(1'b1, `OFS_CTRL, 32'h5);
		rd_chk("clear", `OFS_STATUS, 32'h20, '1);
		// Eight-times oversampling, 7 bits, msb first, bad parity.
		bus(1'b1, `OFS_MODE, 32'h002A);
		rx({2'b10, 7'h68, 1'b0}, 10, 16, 0, 32'h25, 32'h0B, '1);
		for (int p = 0; p < 4; p++) begin
			bus(1'b1, `OFS_CTRL, 32'h5);
			bus(1'b1, `OFS_MODE, 32'h000C | {23'h0, p[2:0], 6'h00});
			rx({2'b11, 8'h41, 1'b0}, 11, 32, 0, p[0] ? 32'h21 : 32'h25,
				32'h41, '1);
		end
		bus(1'b1, `OFS_CTRL, 32'h5);
		bus(1'b1, `OFS_MODE, 32'h005C);
		rx({2'b10, 9'h1C3, 1'b0}, 12, 32, 0, 32'h21, 32'h1C3, '1);
		bus(1'b1, `OFS_MODE, 32'h010C);
		rx({2'b10, 8'h0F, 1'b0}, 11, 32, 0, 32'h29, 32'h0F, '1);
		bus(1'b1, `OFS_CTRL, 32'h5);
		rd_chk("frame clr", `OFS_STATUS, 32'h20, '1);
		// The low stop bit stays low for half a bit after its sample,
		// which is a valid start: an all-ones character follows.
		rx('1, 0, 32, 0, 32'h21, 32'hFF, '1);
		bus(1'b1, `OFS_MODE, 32'h010D);
		rx({1'b1, 8'hC3, 1'b0}, 10, 16, 1, 32'h21, 32'hC3, '1);
		// Manchester with a one-bit delimiter and no preamble.
		bus(1'b1, `OFS_MODE, 32'h190C);
		m = me(16'h00D2);
		rx({1'b1, m[15:0], 2'b10}, 19, 16, 0, 32'h21, 32'hD2,
			32'h1FF);
		// Two zero preamble bits, then command and data syncs.
		bus(1'b1, `OFS_MODE, 32'h090C);
		bus(1'b1, `OFS_MAN, 32'h12);
		rx({1'b1, m[15:0], 10'b0001111010}, 27, 16, 0, 32'h21, 32'h80D2,
			'1);
		rx({1'b1, m[15:0], 10'b1110001010}, 27, 16, 0, 32'h21, 32'hD2,
			'1);
		// Inverted line, zero-one preamble, one-bit delimiter; the first
		// unit raises the inverted idle line so that the hunt is armed.
		bus(1'b1, `OFS_MODE, 32'h010C);
		bus(1'b1, `OFS_MAN, 32'h72);
		bus(1'b1, `OFS_MODE, 32'h190C);
		rx({~m[15:0], 7'b0110010}, 23, 16, 0, 32'h21, 32'hD2,
			'1);
		// Cell three lacks its mid-cell transition.
		bus(1'b1, `OFS_MODE, 32'h190C);
		bus(1'b1, `OFS_MAN, 32'h0);
		m[7:6] = 2'b11;
		i_line_tx.send({1'b1, m[15:0], 2'b10}, 19, 16, 1'b0);
		rd_chk("code err", `OFS_STATUS, 32'h10, 32'h10);
		bus(1'b1, `OFS_CTRL, 32'h5);
		rd_chk("code clr", `OFS_STATUS, 32'h0, 32'h10);
		final_report;
	end
endmodule
